// >>> shared/power_mode_pkg.sv
package power_mode_pkg;

	// =========================================================
	// Power modes
	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'b00,
		MODE_IDLE     = 2'b01,
		MODE_STOP     = 2'b10,
		MODE_SHUTDOWN = 2'b11
	} power_mode_t;

	// =========================================================
	// Port match width and reset values
	localparam int          PORT_WIDTH      = 8;
	localparam logic [15:0] RESET_VECTOR    = 16'h0000;
	localparam logic [7:0]  PORT_MATCH_RST  = 8'h00;
	localparam logic [7:0]  PORT_MASK_RST   = 8'h00;

	// =========================================================
	// Control bits written by the core in one instruction.
	typedef struct packed {
		logic idle_req;
		logic stop_req;
		logic regulator_shutdown_select;
	} power_control_reg_t;

	// Domain enables driven towards the rest of the chip.
	typedef struct packed {
		logic cpu_run;
		logic osc_run;
		logic periph_run;
		logic regulator_on;
	} power_domain_t;

endpackage

// >>> logic/power_mode_controller.sv
`timescale 1ns/100ps

// Behaviour
// - Idle request halts CPU after write instruction
// - Idle keeps state, peripherals keep running
// - Enabled interrupt or reset ends idle
// - Interrupt wake clears idle bit, CPU resumes
// - Service interrupt, return after idle instruction
// - Reset exit restarts fetch at zero
// - Stop request, select clear, enters stop
// - Stop halts oscillator, CPU, digital peripherals
// - Only reset leaves stop mode
// - Stop with select set enters shutdown
// - Shutdown removes power, nothing retained
// - Only pin or power-on reset exits shutdown
// - Port match change wakes idle, interrupts
module power_mode_controller
	import power_mode_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	// Reset sources, already in the clock domain
	input  wire logic                    pin_reset,
	input  wire logic                    por_reset,
	input  wire logic                    internal_reset,
	// Core write of the power control bits
	input  wire logic                    ctrl_write,
	input  wire power_control_reg_t      ctrl_data,
	input  wire logic                    instr_done,
	// Interrupts
	input  wire logic                    irq_enabled_pending,
	// Port match
	input  wire logic [PORT_WIDTH-1:0]   port_pins,
	input  wire logic [PORT_WIDTH-1:0]   port_match_value,
	input  wire logic [PORT_WIDTH-1:0]   port_match_mask,
	// Status and control outputs
	output power_mode_t                  mode,
	output power_control_reg_t           power_control_reg,
	output power_domain_t                domains,
	output logic                         port_match_irq,
	output logic                         restart_fetch,
	output logic [15:0]                  fetch_address
);

	// =========================================================
	// Helper functions

	// The decoding below is shared by the mode machine and the enables.
	// It is kept in functions so that both always see the same meaning
	// of the control bits and of each mode.

	// Control bits that apply in this cycle. A write that is still in
	// flight wins over the stored copy, so that an entry which ends in
	// the same cycle as its write sees the new bits.
	function automatic power_control_reg_t live_ctrl(
		input logic               wr,
		input power_control_reg_t wdata,
		input power_control_reg_t held
	);
		live_ctrl = wr ? wdata : held;
	endfunction

	// True when the bits ask for any low power mode at all.
	function automatic logic wants_entry(input power_control_reg_t c);
		wants_entry = c.idle_req | c.stop_req;
	endfunction

	// Mode that a finished request leads to. Stop wins over idle, and
	// the regulator select turns a stop into a shutdown, after which
	// the regulator enable drops with the other domains.
	function automatic power_mode_t target_mode(input power_control_reg_t c);
		power_mode_t m;
		m = MODE_IDLE;
		if (c.stop_req) begin
			if (c.regulator_shutdown_select) begin
				m = MODE_SHUTDOWN;
			end else begin
				m = MODE_STOP;
			end
		end
		target_mode = m;
	endfunction

	// Domain enables that belong to a mode. Idle stops only the CPU so
	// that peripherals and memories keep running and keep their state.
	function automatic power_domain_t mode_domains(input power_mode_t m);
		power_domain_t d;
		d = '1;
		case (m)
			MODE_IDLE: begin
				d.cpu_run = 1'b0;
			end
			MODE_STOP: begin
				d.cpu_run    = 1'b0;
				d.osc_run    = 1'b0;
				d.periph_run = 1'b0;
			end
			MODE_SHUTDOWN: begin
				d = '0;
			end
			default: begin
				d = '1;
			end
		endcase
		mode_domains = d;
	endfunction

	// True when any watched pin differs from its match value. Pins whose
	// mask bit is clear never take part in the comparison.
	function automatic logic port_mismatch(
		input logic [PORT_WIDTH-1:0] pins,
		input logic [PORT_WIDTH-1:0] value,
		input logic [PORT_WIDTH-1:0] mask
	);
		port_mismatch = ((pins ^ value) & mask) != '0;
	endfunction

	// =========================================================
	// Port pin synchroniser and match detector

	// Pins come from outside the clock domain, so they pass two flops
	// before the match logic reads them. Only the second flop is read.
	logic [PORT_WIDTH-1:0] pin_meta_r;
	logic [PORT_WIDTH-1:0] pin_sync_r;
	logic                  match_r;
	logic                  match_nxt;
	logic                  match_evt_r;
	logic                  match_evt_nxt;

	always_comb begin
		// A wake event is the first cycle of a mismatch, not its level.
		match_nxt     = port_mismatch(pin_sync_r, port_match_value, port_match_mask);
		match_evt_nxt = match_nxt & ~match_r;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_r  <= PORT_MASK_RST;
			pin_sync_r  <= PORT_MASK_RST;
			match_r     <= 1'b0;
			match_evt_r <= 1'b0;
		end else begin
			pin_meta_r  <= port_pins;
			pin_sync_r  <= pin_meta_r;
			match_r     <= match_nxt;
			match_evt_r <= match_evt_nxt;
		end
	end

	// =========================================================
	// Wake and reset sources

	// Every reset source ends idle and stop. Shutdown has the regulator
	// off, so only the pin and power-on resets can bring it back.
	// An enabled interrupt and a port match both wake idle; neither is
	// looked at in stop or shutdown.
	logic any_reset;
	logic hard_reset;
	logic wake_idle;

	always_comb begin
		any_reset  = pin_reset | por_reset | internal_reset;
		hard_reset = pin_reset | por_reset;
		wake_idle  = irq_enabled_pending | match_evt_r;
	end

	// =========================================================
	// Mode state machine

	// A request is remembered in pend_r until its instruction retires.
	// The restart pulse tells the core to run its reset sequence and to
	// fetch from the reset vector. It lasts one cycle, and a reset that
	// is held for longer simply repeats it.
	power_mode_t        mode_r;
	power_mode_t        mode_nxt;
	power_control_reg_t ctrl_r;
	power_control_reg_t ctrl_nxt;
	logic               pend_r;
	logic               pend_nxt;
	logic               restart_r;
	logic               restart_nxt;

	always_comb begin
		mode_nxt    = mode_r;
		ctrl_nxt    = ctrl_r;
		pend_nxt    = pend_r;
		restart_nxt = 1'b0;
		case (mode_r)
			MODE_NORMAL: begin
				if (any_reset) begin
					ctrl_nxt    = '0;
					pend_nxt    = 1'b0;
					restart_nxt = 1'b1;
				end else begin
					if (ctrl_write) begin
						ctrl_nxt = ctrl_data;
						pend_nxt = ctrl_data.idle_req | ctrl_data.stop_req;
					end
					// A write with no request bits only stores them.
					// Entry waits for the writing instruction to retire, so the
					// CPU halts after it and resumes at the one that follows.
					if (ctrl_write ? wants_entry(ctrl_data) : pend_r) begin
						if (instr_done) begin
							pend_nxt = 1'b0;
							mode_nxt = target_mode(live_ctrl(ctrl_write, ctrl_data, ctrl_r));
						end
					end
				end
			end
			MODE_IDLE: begin
				// Registers and memories keep their contents; only the CPU
				// clock is held, so a wake simply lets it run on.
				if (any_reset) begin
					mode_nxt    = MODE_NORMAL;
					ctrl_nxt    = '0;
					restart_nxt = 1'b1;
				end else if (wake_idle) begin
					// The core services the interrupt and returns to the
					// instruction after the one that asked for idle.
					mode_nxt          = MODE_NORMAL;
					ctrl_nxt.idle_req = 1'b0;
				end
			end
			MODE_STOP: begin
				// Interrupts and port matches are ignored here; the
				// oscillator is off, so only a reset restarts the core.
				if (any_reset) begin
					mode_nxt    = MODE_NORMAL;
					ctrl_nxt    = '0;
					restart_nxt = 1'b1;
				end
			end
			MODE_SHUTDOWN: begin
				// Nothing is retained, and the internal reset logic is not
				// powered, so only the pin or power-on reset counts.
				if (hard_reset) begin
					mode_nxt    = MODE_NORMAL;
					ctrl_nxt    = '0;
					restart_nxt = 1'b1;
				end
			end
			default: begin
				mode_nxt = MODE_NORMAL;
				ctrl_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r    <= MODE_NORMAL;
			ctrl_r    <= '0;
			pend_r    <= 1'b0;
			restart_r <= 1'b0;
		end else begin
			mode_r    <= mode_nxt;
			ctrl_r    <= ctrl_nxt;
			pend_r    <= pend_nxt;
			restart_r <= restart_nxt;
		end
	end

	// =========================================================
	// Domain enables

	// The enables are registered so that the rest of the chip sees them
	// change in the same cycle as the mode output, never before it.
	// The port match interrupt is registered beside them.
	power_domain_t dom_r;
	power_domain_t dom_nxt;
	logic          irq_r;
	logic          irq_nxt;

	always_comb begin
		// Enables follow the next mode so that they change together with it.
		dom_nxt = mode_domains(mode_nxt);
		// No port match interrupt while the digital logic is stopped.
		irq_nxt = match_evt_r & (mode_r != MODE_STOP) & (mode_r != MODE_SHUTDOWN);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dom_r <= '1;
			irq_r <= 1'b0;
		end else begin
			dom_r <= dom_nxt;
			irq_r <= irq_nxt;
		end
	end

	// =========================================================
	// Outputs

	// Every output comes straight from a flop; the fetch address is fixed.
	assign mode              = mode_r;
	assign power_control_reg = ctrl_r;
	assign domains           = dom_r;
	assign port_match_irq    = irq_r;
	assign restart_fetch     = restart_r;
	assign fetch_address     = RESET_VECTOR;

endmodule

// >>> tb/pmc_core_model.sv
`timescale 1ns/100ps
// =======
// Core that writes the control bits and retires the writing instruction after a lag.
module pmc_core_model
	import power_mode_pkg::*;
(
	input  wire logic          clk,
	output logic               ctrl_write = 0,
	output power_control_reg_t ctrl_data = 0,
	output logic               instr_done = 0
);
	task automatic write(input power_control_reg_t d, input int lag);
		@(posedge clk) #1;
		ctrl_write = 1;
		ctrl_data = d;
		instr_done = lag == 0;
		@(posedge clk) #1;
		ctrl_write = 0;
		ctrl_data = ~d;
		instr_done = 0;
		if (lag > 0) begin
			repeat (lag - 1) @(posedge clk) #1;
			instr_done = 1;
			@(posedge clk) #1;
			instr_done = 0;
		end
	endtask
endmodule

// >>> tb/power_mode_controller_asserts.sv
`timescale 1ns/100ps
// =======
// Mode checks.
module power_mode_controller_asserts
	import power_mode_pkg::*;
(
	input wire logic clk, rst_b, pin_reset, por_reset, internal_reset,
	input wire logic ctrl_write, instr_done, irq_enabled_pending,
	input wire logic port_match_irq, restart_fetch,
	input wire logic [15:0] fetch_address,
	input wire power_control_reg_t ctrl_data, power_control_reg,
	input wire power_mode_t mode,
	input wire power_domain_t domains
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire hrd = pin_reset | por_reset;
	wire rs = hrd | (internal_reset & mode != MODE_SHUTDOWN);
	wire wr = ctrl_write & instr_done & mode == MODE_NORMAL & !rs;
	sequence s_pulse; rs ##1 !rs; endsequence
	property p_idle; wr && ctrl_data == 3'b100 |=> mode == MODE_IDLE; endproperty
	a_idle: assert property (p_idle) else $error("idle entry");
	property p_keep; mode == MODE_IDLE |-> domains == 4'b0111; endproperty
	a_keep: assert property (p_keep) else $error("idle domains");
	property p_wake; mode == MODE_IDLE && irq_enabled_pending && !rs
		|=> mode == MODE_NORMAL && !power_control_reg.idle_req; endproperty
	a_wake: assert property (p_wake) else $error("idle wake");
	property p_stop; wr && ctrl_data == 3'b010
		|=> mode == MODE_STOP && domains == 4'b0001; endproperty
	a_stop: assert property (p_stop) else $error("stop entry");
	property p_stay; mode == MODE_STOP && !rs |=> mode == MODE_STOP && !port_match_irq; endproperty
	a_stay: assert property (p_stay) else $error("stop left");
	property p_shut; wr && ctrl_data == 3'b011
		|=> mode == MODE_SHUTDOWN && domains == 4'b0000; endproperty
	a_shut: assert property (p_shut) else $error("shutdown entry");
	property p_off; mode == MODE_SHUTDOWN && !hrd |=> mode == MODE_SHUTDOWN; endproperty
	a_off: assert property (p_off) else $error("shutdown left");
	property p_clr; rs |=> mode == MODE_NORMAL && power_control_reg == 3'b000; endproperty
	a_clr: assert property (p_clr) else $error("reset exit");
	property p_fetch; s_pulse |-> ##[0:2] restart_fetch && fetch_address == RESET_VECTOR;
	endproperty
	a_fetch: assert property (p_fetch) else $error("restart fetch");
endmodule
bind power_mode_controller power_mode_controller_asserts chk_u (.*);

// >>> tb/tb_power_mode_controller.sv
`timescale 1ns/100ps
// =======
// Scenario bench.
module tb_power_mode_controller
	import power_mode_pkg::*;
;
	logic clk = 0, rst_b = 0, irq = 0, cw, id, pmi, rf;
	logic [2:0] rs = 0;
	logic [7:0] pins = 0;
	logic [15:0] fa;
	int errors = 0, checked = 0;
	power_control_reg_t cd, pcr;
	power_mode_t mode;
	power_domain_t dom;
	always #50 clk = ~clk;
	pmc_core_model core_u (.clk(clk), .ctrl_write(cw), .ctrl_data(cd), .instr_done(id));
	power_mode_controller dut_u (.clk(clk), .rst_b(rst_b), .pin_reset(rs[0]),
		.por_reset(rs[1]), .internal_reset(rs[2]), .ctrl_write(cw), .ctrl_data(cd),
		.instr_done(id), .irq_enabled_pending(irq), .port_pins(pins),
		.port_match_value(8'h00), .port_match_mask(8'h0f), .mode(mode),
		.power_control_reg(pcr), .domains(dom), .port_match_irq(pmi),
		.restart_fetch(rf), .fetch_address(fa));
	task automatic chk(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic [2:0] v);
		rs = v;
		cyc(1);
		rs = 0;
		cyc(2);
	endtask
	task automatic results;
		if (errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic t_idle;
		core_u.write(3'b100, 1);
		chk(mode, MODE_IDLE);
		chk(dom, 4'b0111);
		irq = 1;
		cyc(2);
		irq = 0;
		chk(mode, MODE_NORMAL);
		chk(pcr, 3'b000);
		core_u.write(3'b100, 0);
		pins = 8'h04;
		cyc(4);
		chk(pmi, 1'b1);
		chk(mode, MODE_NORMAL);
		cyc(1);
		chk(pmi, 1'b0);
		pins = 0;
	endtask
	task automatic t_stop;
		core_u.write(3'b010, 0);
		chk(dom, 4'b0001);
		irq = 1;
		pins = 8'h01;
		cyc(6);
		irq = 0;
		chk(mode, MODE_STOP);
		pulse(3'b100);
		chk(pcr, 3'b000);
		pins = 0;
	endtask
	task automatic t_shut;
		core_u.write(3'b011, 2);
		chk(dom, 4'b0000);
		pulse(3'b100);
		chk(mode, MODE_SHUTDOWN);
		pulse(3'b001);
		chk(mode, MODE_NORMAL);
	endtask
	task automatic t_reset;
		int i;
		core_u.write(3'b100, 0);
		rs = 3'b010;
		cyc(1);
		rs = 0;
		for (i = 0; i < 3 && rf !== 1'b1; i++) cyc(1);
		chk(rf, 1'b1);
		chk(fa, RESET_VECTOR);
	endtask
	initial begin
		cyc(16);
		rst_b = 1;
		cyc(1);
		t_idle;
		t_stop;
		t_shut;
		t_reset;
		results;
	end
	initial begin
		#200000;
		errors++;
		results;
	end
endmodule
